// [design/pcsc_pkg.sv]
package pcsc_pkg;
  // ***************************************************************
  // chain geometry
  // ***************************************************************
  localparam int CHAIN_LEN = 67;
  localparam int RSV_POS_A = 57;  // reserved pad positions, 1-based
  localparam int RSV_POS_B = 58;
  // ***************************************************************
  // timing
  // ***************************************************************
  localparam int CORE_CLK_MHZ = 50;
  localparam int SEN_LEAD_NS = 3;  // tester lead of scan enable
  localparam int SEN_LEAD_CYC = (SEN_LEAD_NS * CORE_CLK_MHZ + 999) / 1000 < 1 ? 1 :
    (SEN_LEAD_NS * CORE_CLK_MHZ + 999) / 1000;
  // ***************************************************************
  // reset values
  // ***************************************************************
  localparam logic RST_LEVEL = 1'b0;
  // ***************************************************************
  // termination mode codes
  // ***************************************************************
  typedef enum logic [1:0] {
    PCSC_TERM_OFF = 2'h0,
    PCSC_TERM_NOMINAL = 2'h1,
    PCSC_TERM_NORMAL = 2'h2
  } pcsc_term_t;
endpackage

// [design/pcsc_sync.sv]
`timescale 1ns/1ns
`default_nettype none
// two-stage level synchroniser into the core domain
module pcsc_sync
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic d_i,
  output logic q_o
);
  typedef struct packed {
    logic s1;
    logic s2;
  } pcsc_sync_st_t;
  pcsc_sync_st_t st_r;
  pcsc_sync_st_t st_nxt;
  // first stage feeds only the second
  always_comb
  begin
    st_nxt.s1 = d_i;
    st_nxt.s2 = st_r.s1;
  end
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end
  assign q_o = st_r.s2;
endmodule
`default_nettype wire

// [design/pcsc_top.sv]
`timescale 1ns/1ns
`default_nettype none
// Functional notes
// - scan mode is active while scan_enable is high and off while it is low.
// - with scan_enable low the shared pins keep their memory functions.
// - in scan mode mirroring is off and the chain follows the unmirrored pads.
// - the chain has 67 positions, bit 1 first, and shifts zeros in after the last.
// - positions 57 and 58 are reserved and always read zero.
// - on a scan clock rise, shift select low captures pads and high shifts one place.
// - scan inputs are sampled on scan clock rises, which may be single pulses or bursts.
// - the serial output drives only while the output gate was registered high.
// - no commands execute while scan_enable is high.
// - in scan mode address/control termination is nominal and data termination off.
module pcsc_top
#(
  parameter int CHAIN_W = pcsc_pkg::CHAIN_LEN
)
(
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  input wire logic scan_clk_i,
  input wire logic scan_enable_i,
  input wire logic scan_shift_select_i,
  input wire logic scan_output_gate_i,
  input wire logic [CHAIN_W-1:0] pad_level_i,
  input wire logic mirror_function_pin_i,
  input wire logic cmd_valid_i,
  output logic scan_serial_output_o,
  output logic scan_serial_output_oe_o,
  output logic cmd_exec_o,
  output logic mirror_active_o,
  output logic [1:0] ca_term_mode_o,
  output logic [1:0] dq_term_mode_o,
  output logic scan_mode_o
);
  // ***************************************************************
  // reset release, core domain
  // ***************************************************************
  logic [1:0] rst_sync_r;
  always_ff @(posedge core_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      rst_sync_r <= 2'h0;
    else
      rst_sync_r <= {rst_sync_r[0], 1'b1};
  end
  logic rst_n;
  assign rst_n = rst_sync_r[1];

  // ***************************************************************
  // scan clock domain: the chain itself
  // ***************************************************************
  // bit 0 is chain position 1, the one presented at the output
  function automatic logic [CHAIN_W-1:0] pcsc_capture(input logic [CHAIN_W-1:0] pads);
    logic [CHAIN_W-1:0] v;
    v = pads;
    v[pcsc_pkg::RSV_POS_A-1] = 1'b0;
    v[pcsc_pkg::RSV_POS_B-1] = 1'b0;
    return v;
  endfunction

  typedef struct packed {
    logic [CHAIN_W-1:0] chain;
    logic gate;
  } pcsc_scan_st_t;
  pcsc_scan_st_t sc_r;
  pcsc_scan_st_t sc_nxt;

  // capture or shift per rising scan clock edge
  always_comb
  begin
    sc_nxt = sc_r;
    if (scan_enable_i)
    begin
      sc_nxt.gate = scan_output_gate_i;
      if (!scan_shift_select_i)
        sc_nxt.chain = pcsc_capture(pad_level_i);
      else
        sc_nxt.chain = {1'b0, sc_r.chain[CHAIN_W-1:1]};
    end
    else
      sc_nxt.gate = 1'b0;
  end
  // pulses or bursts only; no edge is assumed outside them
  always_ff @(posedge scan_clk_i or negedge rst_n)
  begin
    if (!rst_n)
      sc_r <= '0;
    else
      sc_r <= sc_nxt;
  end

  // serial output pin direct from scan-domain flops
  assign scan_serial_output_o = sc_r.chain[0];
  assign scan_serial_output_oe_o = sc_r.gate & scan_enable_i;

  // ***************************************************************
  // core domain: command gating and termination
  // ***************************************************************
  logic scan_en_s;
  logic mirror_s;
  pcsc_sync u_sync_en
  (
    .clk_i(core_clk_i),
    .rst_n_i(rst_n),
    .d_i(scan_enable_i),
    .q_o(scan_en_s)
  );
  pcsc_sync u_sync_mf
  (
    .clk_i(core_clk_i),
    .rst_n_i(rst_n),
    .d_i(mirror_function_pin_i),
    .q_o(mirror_s)
  );

  typedef struct packed {
    logic exec;
    logic mirror;
    logic [1:0] ca_term;
    logic [1:0] dq_term;
    logic mode;
  } pcsc_core_st_t;
  pcsc_core_st_t co_r;
  pcsc_core_st_t co_nxt;

  // mode follows scan_enable; commands blocked while in scan
  always_comb
  begin
    co_nxt.mode = scan_en_s;
    co_nxt.exec = cmd_valid_i & ~scan_en_s;
    co_nxt.mirror = mirror_s & ~scan_en_s;
    if (scan_en_s)
    begin
      co_nxt.ca_term = pcsc_pkg::PCSC_TERM_NOMINAL;
      co_nxt.dq_term = pcsc_pkg::PCSC_TERM_OFF;
    end
    else
    begin
      co_nxt.ca_term = pcsc_pkg::PCSC_TERM_NORMAL;
      co_nxt.dq_term = pcsc_pkg::PCSC_TERM_NORMAL;
    end
  end
  always_ff @(posedge core_clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      co_r.exec <= 1'b0;
      co_r.mirror <= 1'b0;
      co_r.ca_term <= pcsc_pkg::PCSC_TERM_NORMAL;
      co_r.dq_term <= pcsc_pkg::PCSC_TERM_NORMAL;
      co_r.mode <= 1'b0;
    end
    else
      co_r <= co_nxt;
  end

  assign cmd_exec_o = co_r.exec;
  assign mirror_active_o = co_r.mirror;
  assign ca_term_mode_o = co_r.ca_term;
  assign dq_term_mode_o = co_r.dq_term;
  assign scan_mode_o = co_r.mode;

  // ***************************************************************
  // checks
  // ***************************************************************
  rsv_zero_a: assert property (@(posedge scan_clk_i) disable iff (!rst_n)
    (scan_enable_i && !scan_shift_select_i) |=>
    (sc_r.chain[pcsc_pkg::RSV_POS_A-1] == 1'b0 && sc_r.chain[pcsc_pkg::RSV_POS_B-1] == 1'b0))
    else $error("reserved position not zero after capture");
  shift_step_a: assert property (@(posedge scan_clk_i) disable iff (!rst_n)
    (scan_enable_i && scan_shift_select_i) |=> sc_r.chain[CHAIN_W-2:0] == $past(sc_r.chain[CHAIN_W-1:1]))
    else $error("chain did not advance one place");
  zero_fill_a: assert property (@(posedge scan_clk_i) disable iff (!rst_n)
    (scan_enable_i && scan_shift_select_i) |=> !sc_r.chain[CHAIN_W-1])
    else $error("top of chain not zero filled");
  capture_pad_a: assert property (@(posedge scan_clk_i) disable iff (!rst_n)
    (scan_enable_i && !scan_shift_select_i) |=> sc_r.chain[0] == $past(pad_level_i[0]))
    else $error("capture did not load pad");
  out_gate_a: assert property (@(posedge scan_clk_i) disable iff (!rst_n)
    (scan_enable_i && !scan_output_gate_i) |=> !sc_r.gate)
    else $error("output enabled without gate");
  no_cmd_a: assert property (@(posedge core_clk_i) disable iff (!rst_n)
    scan_en_s |=> !cmd_exec_o)
    else $error("command executed in scan mode");
  term_scan_a: assert property (@(posedge core_clk_i) disable iff (!rst_n)
    scan_en_s |=> (ca_term_mode_o == pcsc_pkg::PCSC_TERM_NOMINAL && dq_term_mode_o == pcsc_pkg::PCSC_TERM_OFF))
    else $error("termination wrong in scan mode");
  mirror_off_a: assert property (@(posedge core_clk_i) disable iff (!rst_n)
    scan_mode_o |-> !mirror_active_o)
    else $error("mirror active in scan mode");
  mode_track_a: assert property (@(posedge core_clk_i) disable iff (!rst_n)
    $rose(scan_en_s) |=> scan_mode_o)
    else $error("scan mode not entered");
  mode_fall_a: assert property (@(posedge core_clk_i) disable iff (!rst_n)
    $fell(scan_en_s) |=> !scan_mode_o)
    else $error("scan mode not left");

  // scan domain: gate registration and serial output
  gate_on_a: assert property (@(posedge scan_clk_i) disable iff (!rst_n)
    (scan_enable_i && scan_output_gate_i) |=> sc_r.gate)
    else $error("output gate not registered");
  oe_off_a: assert property (@(posedge scan_clk_i) disable iff (!rst_n)
    !scan_output_gate_i |=> !scan_serial_output_oe_o)
    else $error("output driven with gate low");
  pos_one_a: assert property (@(posedge scan_clk_i) disable iff (!rst_n)
    (scan_enable_i && scan_shift_select_i) |=> scan_serial_output_o == $past(sc_r.chain[1]))
    else $error("output not next chain position");

  // core domain: ordinary roles while out of scan
  exec_pass_a: assert property (@(posedge core_clk_i) disable iff (!rst_n)
    !scan_en_s |=> cmd_exec_o == $past(cmd_valid_i))
    else $error("command not passed in normal mode");
  mirror_pass_a: assert property (@(posedge core_clk_i) disable iff (!rst_n)
    !scan_en_s |=> mirror_active_o == $past(mirror_s))
    else $error("mirror not passed in normal mode");
  term_norm_a: assert property (@(posedge core_clk_i) disable iff (!rst_n)
    !scan_en_s |=> (ca_term_mode_o == pcsc_pkg::PCSC_TERM_NORMAL && dq_term_mode_o == pcsc_pkg::PCSC_TERM_NORMAL))
    else $error("termination wrong in normal mode");
endmodule
`default_nettype wire

// [bench/pcsc_tester.sv]
`timescale 1ns/1ns
`default_nettype none
// test equipment at the scan pins; scan clock idles low between frames
module pcsc_tester
(
  output logic scan_clk_o,
  output logic scan_enable_o,
  output logic shift_sel_o,
  output logic gate_o
);
  // idle levels, scan enable held low while unused
  initial
  begin
    scan_clk_o = 1'b0;
    scan_enable_o = 1'b0;
    shift_sel_o = 1'b0;
    gate_o = 1'b0;
  end
  // mode change only after init, long before other controls move
  task automatic set_mode(input logic en);
    scan_enable_o = en;
  endtask
  // one 80 ns period, clock high for 40 ns, controls set half a period ahead of the rise
  task automatic pulse(input logic scan_shift_select, input logic g);
    shift_sel_o = scan_shift_select;
    gate_o = g;
    #40 scan_clk_o = 1'b1;
    #40 scan_clk_o = 1'b0;
  endtask
endmodule
`default_nettype wire

// [bench/testbench.sv]
`timescale 1ns/1ns
`default_nettype none
module testbench;
  logic core_clk = 1'b0;
  logic reset_n = 1'b0;
  logic mirror_pin = 1'b1;
  logic cmd_valid = 1'b0;
  logic [66:0] pads = 67'h5_A7C3_0FF0_96E7_3B1D;
  logic sclk, scan_enable, scan_shift_select, gate, scan_serial_output, scan_output_gate, exec, mir, smode;
  logic [1:0] ca_t, dq_t;
  int n_fail = 0;
  int total_checks = 0;
  // ***************************************************************
  // clock and watchdog
  // ***************************************************************
  initial
  begin
    forever #10 core_clk = ~core_clk;
  end
  initial
  begin
    #200000;
    n_fail++;
    end_sim();
  end
  pcsc_tester tester (.scan_clk_o(sclk), .scan_enable_o(scan_enable), .shift_sel_o(scan_shift_select), .gate_o(gate));
  pcsc_top dut (.core_clk_i(core_clk), .reset_n_i(reset_n), .scan_clk_i(sclk), .scan_enable_i(scan_enable),
    .scan_shift_select_i(scan_shift_select), .scan_output_gate_i(gate), .pad_level_i(pads),
    .mirror_function_pin_i(mirror_pin), .cmd_valid_i(cmd_valid), .scan_serial_output_o(scan_serial_output),
    .scan_serial_output_oe_o(scan_output_gate), .cmd_exec_o(exec), .mirror_active_o(mir),
    .ca_term_mode_o(ca_t), .dq_term_mode_o(dq_t), .scan_mode_o(smode));
  // ***************************************************************
  // helpers
  // ***************************************************************
  task automatic chk(input logic [1:0] seen, input logic [1:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("[ERR] %0t saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
    #2;
  endtask
  // ***************************************************************
  // scenarios
  // ***************************************************************
  // normal mode: commands run, memory roles kept
  task automatic t_normal();
    cmd_valid = 1'b1;
    cyc(1);
    cmd_valid = 1'b0;
    chk({1'b0, exec}, 2'h1);
    chk({1'b0, mir}, 2'h1);
    chk({1'b0, smode}, 2'h0);
    chk(ca_t, pcsc_pkg::PCSC_TERM_NORMAL);
    chk(dq_t, pcsc_pkg::PCSC_TERM_NORMAL);
    $display("normal done");
  endtask
  // scan entry: no mirror, fixed terminations, commands dropped
  task automatic t_enter();
    tester.set_mode(1'b1);
    cyc(5);
    chk({1'b0, smode}, 2'h1);
    chk({1'b0, mir}, 2'h0);
    chk(ca_t, pcsc_pkg::PCSC_TERM_NOMINAL);
    chk(dq_t, pcsc_pkg::PCSC_TERM_OFF);
    cmd_valid = 1'b1;
    cyc(1);
    cmd_valid = 1'b0;
    chk({1'b0, exec}, 2'h0);
    $display("enter done");
  endtask
  // capture then shift past the end of the chain
  task automatic t_chain();
    logic e;
    tester.pulse(1'b0, 1'b1);
    chk({1'b0, scan_serial_output}, {1'b0, pads[0]});
    chk({1'b0, scan_output_gate}, 2'h1);
    for (int i = 1; i < 70; i++)
    begin
      tester.pulse(1'b1, 1'b1);
      e = (i > 66 || i == 56 || i == 57) ? 1'b0 : pads[i];
      chk({1'b0, scan_serial_output}, {1'b0, e});
    end
    tester.pulse(1'b1, 1'b0);
    chk({1'b0, scan_output_gate}, 2'h0);
    $display("chain done");
  endtask
  // scan exit, then reset and re-initialisation before normal use
  task automatic t_exit();
    tester.pulse(1'b0, 1'b0);
    chk({1'b0, scan_serial_output}, {1'b0, pads[0]});
    chk({1'b0, scan_output_gate}, 2'h0);
    tester.set_mode(1'b0);
    cyc(5);
    chk({1'b0, smode}, 2'h0);
    chk({1'b0, mir}, 2'h1);
    chk(ca_t, pcsc_pkg::PCSC_TERM_NORMAL);
    chk(dq_t, pcsc_pkg::PCSC_TERM_NORMAL);
    reset_n = 1'b0;
    cyc(3);
    chk({1'b0, scan_serial_output}, 2'h0);
    chk({1'b0, mir}, 2'h0);
    reset_n = 1'b1;
    cyc(6);
    chk({1'b0, mir}, 2'h1);
    cmd_valid = 1'b1;
    cyc(1);
    cmd_valid = 1'b0;
    chk({1'b0, exec}, 2'h1);
    $display("exit done");
  endtask
  // main sequence, reset held 3 cycles
  initial
  begin
    cyc(3);
    reset_n = 1'b1;
    cyc(5);
    t_normal();
    t_enter();
    t_chain();
    t_exit();
    end_sim();
  end
endmodule
`default_nettype wire
